// File: core/crs_buf.sv
`timescale 1ns/100ps
module crs_buf
  import crs_pkg::*;
(
  input  wire logic      clk_i,
  input  wire logic      rst_b_i,
  input  wire crs_beat_s in_beat_i,
  input  wire logic      in_valid_i,
  output wire logic      in_ready_o,
  output wire crs_beat_s out_beat_o,
  output wire logic      out_valid_o,
  input  wire logic      out_ready_i
);

  crs_beat_s  mem_r [2];
  logic [1:0] cnt_r;
  logic       wp_r;
  logic       rp_r;
  wire        push = in_valid_i & in_ready_o;
  wire        pop  = out_valid_o & out_ready_i;

  assign in_ready_o  = (cnt_r != BUF_DEPTH);
  assign out_valid_o = (cnt_r != RST_CNT);
  assign out_beat_o  = mem_r[rp_r];

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_r[wp_r] <= in_beat_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_r <= RST_CNT;
      wp_r  <= 1'b0;
      rp_r  <= 1'b0;
    end else begin
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
      wp_r  <= wp_r ^ push;
      rp_r  <= rp_r ^ pop;
    end
  end

  AST_BUF_HOLD: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RQ5
    out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_beat_o))
    else $error("buffered beat changed while stalled");

  COV_BUF_FULL: cover property (@(posedge clk_i) disable iff (!rst_b_i) cnt_r == BUF_DEPTH);

endmodule

// File: core/crs_top.sv
// Notes on behaviour
// RQ1 - sample width 4..20 bits, default 8
// RQ2 - one to four planes, default two
// RQ3 - planes sent in parallel or serially
// RQ4 - input pixels per beat 1,2,4,8
// RQ5 - output pixels per beat 1,2,4,8
// RQ6 - variable format side: neither, input, output
// RQ7 - enabled input formats 444, 422, 420
// RQ8 - enabled output formats 444, 422, 420
// RQ9 - input and output formats must differ
// RQ10 - no odd frame sizes in 422
// RQ11 - serial planes of pixel in order
// RQ12 - format code 0=420, 1=422, 2=444
// RQ13 - starts stopped until run enable set
// RQ14 - stop only at frame end
// RQ15 - user packets forbidden, dropped or passed
`timescale 1ns/100ps
module crs_top
  import crs_pkg::*;
(
  input  wire logic              CLOCK_I,
  input  wire logic              RST_B_I,
  input  wire logic [DW_IN-1:0]  DIN_DATA_I,
  input  wire logic              DIN_VALID_I,
  input  wire logic              DIN_SOP_I,
  input  wire logic              DIN_EOP_I,
  output wire logic              DIN_READY_O,
  output wire logic [DW_OUT-1:0] DOUT_DATA_O,
  output wire logic              DOUT_VALID_O,
  output wire logic              DOUT_SOP_O,
  output wire logic              DOUT_EOP_O,
  input  wire logic              DOUT_READY_I,
  output wire logic [1:0]        DOUT_PLANE_O,
  input  wire logic              RUN_ENABLE_I,
  input  wire logic [1:0]        RUN_FMT_I,
  output wire logic              BUSY_O,
  output wire logic [1:0]        IN_FMT_O,
  output wire logic [1:0]        OUT_FMT_O,
  output wire logic              FMT_ERR_O
);

  function automatic logic fmt_ok(input logic [1:0] code, input logic [2:0] en);
    return (code == 2'h3) ? 1'b0 : en[code];
  endfunction

  function automatic logic [1:0] fixed_fmt(input logic [2:0] en);
    return en[2] ? FMT_444 : (en[1] ? FMT_422 : FMT_420);
  endfunction

  crs_state_e state_r;
  crs_state_e state_nxt;
  logic [1:0] in_fmt_r;
  logic [1:0] out_fmt_r;
  logic       fmt_err_r;
  logic [1:0] plane_r;
  logic [1:0] plane_nxt;
  crs_beat_s  buf_in;
  crs_beat_s  buf_out;
  logic       buf_in_ready;

  // control port takes effect only with a variable side
  // RQ6 variable side select
  wire        ctrl_en  = (VAR_SIDE != VAR_NONE);
  // RQ13 stopped until enabled
  wire        go_eff   = ctrl_en ? RUN_ENABLE_I : 1'b1;
  wire [3:0]  pkt_type = DIN_DATA_I[3:0];
  wire        idle     = (state_r == ST_IDLE);
  wire        is_video = (pkt_type == PKT_VIDEO);
  wire        is_ctrl  = (pkt_type == PKT_CTRL);
  wire        is_user  = !is_video && !is_ctrl;
  // RQ15 user packet handling
  wire        user_ok  = (UP_MODE != UP_FORBID);
  wire        user_drp = is_user && (UP_MODE == UP_DROP);
  wire        start_ok = is_video ? go_eff : (is_user ? user_ok : 1'b1);
  wire        take     = idle && DIN_SOP_I && start_ok;
  wire        drop_bt  = (idle && !DIN_SOP_I) || (take && user_drp) || (state_r == ST_DROP);
  wire        fwd_bt   = idle ? (take && !user_drp) : (state_r != ST_DROP);
  wire        fire_in  = DIN_VALID_I && DIN_READY_O;
  wire        vstart   = fire_in && take && is_video;
  wire        out_fire = DOUT_VALID_O && DOUT_READY_I;

  // RQ12 format code decode
  wire [1:0]  in_sel   = (VAR_SIDE == VAR_IN) ? RUN_FMT_I : fixed_fmt(IN_FMT_EN);
  wire [1:0]  out_sel  = (VAR_SIDE == VAR_OUT) ? RUN_FMT_I : fixed_fmt(OUT_FMT_EN);
  // RQ7 input enable check
  wire        in_bad   = !fmt_ok(in_sel, IN_FMT_EN);
  // RQ8 output enable check
  wire        out_bad  = !fmt_ok(out_sel, OUT_FMT_EN);

  assign DIN_READY_O = drop_bt || (fwd_bt && buf_in_ready);
  // RQ1 samples kept whole
  assign buf_in      = '{data: DIN_DATA_I, sop: DIN_SOP_I, eop: DIN_EOP_I};

  // RQ4 input beat width
  crs_buf u_buf (
    .clk_i       (CLOCK_I),
    .rst_b_i     (RST_B_I),
    .in_beat_i   (buf_in),
    .in_valid_i  (DIN_VALID_I && fwd_bt),
    .in_ready_o  (buf_in_ready),
    .out_beat_o  (buf_out),
    .out_valid_o (DOUT_VALID_O),
    .out_ready_i (DOUT_READY_I)
  );

  // RQ5 output beat width
  assign DOUT_DATA_O  = buf_out.data[DW_OUT-1:0];
  assign DOUT_SOP_O   = buf_out.sop;
  assign DOUT_EOP_O   = buf_out.eop;
  assign DOUT_PLANE_O = plane_r;
  assign BUSY_O       = (state_r == ST_VIDEO);
  assign IN_FMT_O     = in_fmt_r;
  assign OUT_FMT_O    = out_fmt_r;
  assign FMT_ERR_O    = fmt_err_r;

  // RQ14 halt only between frames
  always_comb begin
    state_nxt = state_r;
    if (fire_in) begin
      if (DIN_EOP_I) begin
        state_nxt = ST_IDLE;
      end else begin
        unique case (state_r)
          ST_IDLE: begin
            // a stray beat outside a packet is dropped, whatever its low nibble holds
            if (!DIN_SOP_I) begin
              state_nxt = ST_IDLE;
            end else if (is_video) begin
              state_nxt = ST_VIDEO;
            end else if (user_drp) begin
              state_nxt = ST_DROP;
            end else begin
              state_nxt = ST_PASS;
            end
          end
          ST_VIDEO: state_nxt = ST_VIDEO;
          ST_DROP:  state_nxt = ST_DROP;
          ST_PASS:  state_nxt = ST_PASS;
        endcase
      end
    end
  end

  // RQ11 serial plane order
  // RQ3 serial or parallel planes
  // RQ2 plane count
  assign plane_nxt = (PLANES_PAR || !out_fire) ? plane_r :
                     (DOUT_SOP_O || plane_r == 2'(PLANES - 1)) ? RST_PLANE : plane_r + 2'h1;

  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      state_r   <= ST_IDLE;
      plane_r   <= RST_PLANE;
      in_fmt_r  <= RST_FMT;
      out_fmt_r <= RST_FMT;
      fmt_err_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      plane_r <= plane_nxt;
      if (vstart) begin
        in_fmt_r  <= in_sel;
        out_fmt_r <= out_sel;
        fmt_err_r <= in_bad || out_bad;
      end
    end
  end

  AST_STOPPED_HOLD: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I) // RQ13
    idle && DIN_VALID_I && DIN_SOP_I && is_video && !go_eff |-> !DIN_READY_O)
    else $error("video accepted while stopped");

  AST_FRAME_FINISH: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I) // RQ14
    state_r == ST_VIDEO && fire_in && !DIN_EOP_I |=> state_r == ST_VIDEO && BUSY_O)
    else $error("frame left before its end");

  AST_FMT_SEL: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I) // RQ12
    vstart && RUN_FMT_I == 2'h2 && VAR_SIDE == VAR_IN |=>
    IN_FMT_O == FMT_444 && FMT_ERR_O == (!IN_FMT_EN[2] || $past(out_bad)))
    else $error("format code 2 not taken as 444");

  AST_IN_ENABLE: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I) // RQ7
    vstart && in_bad |=> FMT_ERR_O)
    else $error("disabled input format not flagged");

  AST_OUT_ENABLE: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I) // RQ8
    vstart && !in_bad && !out_bad |=> !FMT_ERR_O && OUT_FMT_O == $past(out_sel))
    else $error("enabled output format flagged");

  AST_DROP_USER: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I) // RQ15
    state_r == ST_DROP |-> DIN_READY_O && !fwd_bt)
    else $error("dropped user packet reached the buffer");

  AST_PLANE_ORDER: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I) // RQ11
    !PLANES_PAR && out_fire && !DOUT_SOP_O && plane_r == 2'(PLANES - 1) |=> plane_r == RST_PLANE)
    else $error("plane index did not wrap");

  AST_PASS_DATA: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I) // RQ1
    fire_in && fwd_bt && !DOUT_VALID_O |=> DOUT_VALID_O && DOUT_DATA_O == $past(DIN_DATA_I))
    else $error("beat not forwarded intact");

  AST_PLANE_PAR: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I) // RQ3
    PLANES_PAR |-> DOUT_PLANE_O == RST_PLANE)
    else $error("plane index moved in parallel build");

  AST_EOP_IDLE: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I) // RQ14
    fire_in && DIN_EOP_I |=> idle && !BUSY_O)
    else $error("packet end did not return to idle");

  AST_FMT_STABLE: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I) // RQ6
    !vstart |=> $stable(IN_FMT_O) && $stable(OUT_FMT_O) && $stable(FMT_ERR_O))
    else $error("format changed outside a frame start");

  AST_STRAY_DROP: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I) // RQ15
    idle && DIN_VALID_I && !DIN_SOP_I |-> DIN_READY_O ##1 idle)
    else $error("stray beat left the idle state");

  COV_FRAME: cover property (@(posedge CLOCK_I) disable iff (!RST_B_I)
    vstart ##[1:20] (state_r == ST_VIDEO && fire_in && DIN_EOP_I));
  COV_STALL: cover property (@(posedge CLOCK_I) disable iff (!RST_B_I)
    idle && DIN_VALID_I && DIN_SOP_I && is_video && !go_eff);
  COV_USER: cover property (@(posedge CLOCK_I) disable iff (!RST_B_I)
    fire_in && take && is_user);
  COV_STRAY: cover property (@(posedge CLOCK_I) disable iff (!RST_B_I)
    idle && fire_in && !DIN_SOP_I);

endmodule

// File: inc/crs_pkg.sv
package crs_pkg;

  // sample width, 4 to 20 bits
  localparam int unsigned BPS        = 8;
  // color planes per pixel, 1 to 4
  localparam int unsigned PLANES     = 2;
  // planes side by side (1) or one per beat (0)
  localparam bit          PLANES_PAR = 1'b1;
  // pixels per beat on each side: 1, 2, 4 or 8
  localparam int unsigned PIX_IN     = 1;
  localparam int unsigned PIX_OUT    = 1;
  localparam int unsigned DW_IN      = PLANES_PAR ? BPS * PLANES * PIX_IN : BPS * PIX_IN;
  localparam int unsigned DW_OUT     = PLANES_PAR ? BPS * PLANES * PIX_OUT : BPS * PIX_OUT;

  typedef enum logic [1:0] {
    VAR_NONE = 2'h0,
    VAR_IN   = 2'h1,
    VAR_OUT  = 2'h2
  } crs_var_e;
  localparam crs_var_e VAR_SIDE = VAR_IN;

  typedef enum logic [1:0] {
    FMT_420 = 2'h0,
    FMT_422 = 2'h1,
    FMT_444 = 2'h2
  } crs_fmt_e;

  // enable masks, bit index is the format code
  localparam logic [2:0] IN_FMT_EN  = 3'h3;
  localparam logic [2:0] OUT_FMT_EN = 3'h4;

  typedef enum logic [1:0] {
    UP_FORBID = 2'h0,
    UP_DROP   = 2'h1,
    UP_PASS   = 2'h2
  } crs_up_e;
  localparam crs_up_e UP_MODE = UP_PASS;

  // packet type sits in the low nibble of the first beat
  localparam logic [3:0] PKT_VIDEO = 4'h0;
  localparam logic [3:0] PKT_CTRL  = 4'hf;

  localparam logic [1:0] RST_FMT   = 2'h0;
  localparam logic [1:0] RST_PLANE = 2'h0;
  localparam logic [1:0] RST_CNT   = 2'h0;
  localparam logic [1:0] BUF_DEPTH = 2'h2;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_VIDEO = 2'b01,
    ST_DROP  = 2'b11,
    ST_PASS  = 2'b10
  } crs_state_e;

  typedef struct packed {
    logic [DW_IN-1:0] data;
    logic             sop;
    logic             eop;
  } crs_beat_s;

endpackage

// File: verif/crs_sink.sv
`timescale 1ns/100ps
// downstream consumer: mode 0 prompt, 1 every other cycle, 2 stalled
module crs_sink (
  input  wire logic       clk_i,
  input  wire logic       rst_b_i,
  input  wire logic [1:0] mode_i,
  output var  logic       ready_o
);
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ready_o <= 1'b0;
    end else begin
      ready_o <= (mode_i == 2'h0) | ((mode_i == 2'h1) & ~ready_o);
    end
  end
endmodule

// File: verif/crs_top_tb_top.sv
`timescale 1ns/100ps
module crs_top_tb_top;
  import crs_pkg::*;
  logic              clk = 1'b0;
  logic              rst_b = 1'b0;
  logic              din_valid = 1'b0;
  logic              din_sop = 1'b0;
  logic              din_eop = 1'b0;
  logic              run_en = 1'b0;
  logic [DW_IN-1:0]  din_data = '0;
  logic [1:0]        run_fmt = 2'h1;
  logic [1:0]        mode = 2'h0;
  wire               din_ready, dout_ready, dout_valid, dout_sop, dout_eop, busy, fmt_err;
  wire [DW_OUT-1:0]  dout_data;
  wire [1:0]         plane, in_fmt, out_fmt;
  int                bad_count = 0;
  int                tests_run = 0;
  logic [17:0]       exp_q[$];

  always #50 clk = ~clk;

  crs_top dut (.CLOCK_I(clk), .RST_B_I(rst_b), .DIN_DATA_I(din_data), .DIN_VALID_I(din_valid),
    .DIN_SOP_I(din_sop), .DIN_EOP_I(din_eop), .DIN_READY_O(din_ready), .DOUT_DATA_O(dout_data),
    .DOUT_VALID_O(dout_valid), .DOUT_SOP_O(dout_sop), .DOUT_EOP_O(dout_eop), .DOUT_READY_I(dout_ready),
    .DOUT_PLANE_O(plane), .RUN_ENABLE_I(run_en), .RUN_FMT_I(run_fmt), .BUSY_O(busy),
    .IN_FMT_O(in_fmt), .OUT_FMT_O(out_fmt), .FMT_ERR_O(fmt_err));
  crs_sink sink (.clk_i(clk), .rst_b_i(rst_b), .mode_i(mode), .ready_o(dout_ready));

  task results;
    if (bad_count == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] want);
    tests_run++;
    if (seen !== want) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, want);
    end
  endtask

  task tick;
    @(posedge clk);
    #1;
  endtask

  task send(input logic [15:0] d, input logic s, input logic e, input bit keep);
    int n;
    n = 0;
    din_valid = 1'b1;
    din_data = d;
    din_sop = s;
    din_eop = e;
    while (din_ready !== 1'b1) begin
      tick;
      n++;
      if (n > 50) begin
        bad_count++;
        results;
      end
    end
    tick;
    if (keep) exp_q.push_back({s, e, d});
  endtask

  // released data lines show the inverse of the last word
  task idle;
    din_valid = 1'b0;
    din_data = ~din_data;
    din_sop = 1'b0;
    din_eop = 1'b0;
    tick;
  endtask

  task refuse;
    din_valid = 1'b1;
    din_sop = 1'b1;
    din_data = 16'h0120;
    repeat (3) begin
      tick;
      chk(din_ready, 0);
    end
    idle;
  endtask

  task frame(input logic [1:0] fmt, input logic [3:0] typ, input bit stop);
    int i;
    run_fmt = fmt;
    send({12'hc3a, typ}, 1'b1, 1'b0, 1'b1);
    if (stop) run_en = 1'b0;
    if (typ == PKT_VIDEO) begin
      chk(fmt_err, (fmt > 2'h2) ? 1'b1 : !IN_FMT_EN[fmt]);
      chk(out_fmt, FMT_444);
      if (fmt != 2'h3) chk(in_fmt, fmt);
    end
    for (i = 0; i < 4; i++) begin
      send({8'(i * 3 + fmt), 8'(~i)}, 1'b0, i == 3, 1'b1);
      if (typ == PKT_VIDEO) chk(busy, i < 3);
    end
    idle;
  endtask

  always @(posedge clk) begin
    if (dout_valid && dout_ready) begin
      chk({dout_sop, dout_eop, dout_data}, exp_q.size() > 0 ? exp_q.pop_front() : 32'hffff_ffff);
      chk(plane, 2'h0);
    end
  end

  initial begin
    int f;
    int n;
    repeat (5) @(posedge clk);
    #1;
    rst_b = 1'b1;
    chk(busy, 0);
    chk(dout_valid, 0);
    chk(fmt_err, 0);
    chk(IN_FMT_EN & OUT_FMT_EN, 3'h0);
    refuse;
    run_en = 1'b1;
    for (f = 0; f < 4; f++) begin
      mode = {1'b0, f[0]};
      frame(f[1:0], PKT_VIDEO, 1'b0);
    end
    mode = 2'h0;
    frame(2'h1, PKT_VIDEO, 1'b1);
    refuse;
    frame(2'h1, 4'h5, 1'b0);
    frame(2'h1, PKT_CTRL, 1'b0);
    send(16'h0070, 1'b0, 1'b0, 1'b0);
    idle;
    run_en = 1'b1;
    mode = 2'h2;
    idle;
    send(16'h0c30, 1'b1, 1'b0, 1'b1);
    send(16'h1111, 1'b0, 1'b0, 1'b1);
    din_data = 16'h2222;
    din_eop = 1'b1;
    tick;
    chk(din_ready, 0);
    mode = 2'h0;
    send(16'h2222, 1'b0, 1'b1, 1'b1);
    idle;
    for (n = 0; n < 20 && exp_q.size() > 0; n++) tick;
    chk(exp_q.size(), 0);
    results;
  end
endmodule
